// file: design/drive_sec_cfg.svh
// Constants of the drive security command gate
`ifndef DRIVE_SEC_CFG_SVH
`define DRIVE_SEC_CFG_SVH

// =========================================
// Register byte addresses
`define ADDR_CMD 8'h00
`define ADDR_DATA 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_SEC 8'h0c
`define ADDR_IRQ_STAT 8'h10
`define ADDR_IRQ_MASK 8'h14

// =========================================
// Opcodes
`define OP_SET_PW 8'hf1
`define OP_UNLOCK 8'hf2
`define OP_PREPARE 8'hf3
`define OP_ERASE 8'hf4
`define OP_FREEZE 8'hf5
`define OP_DISABLE 8'hf6

// =========================================
// Sector layout and counts
`define SECTOR_WORDS 9'h100
`define PW_FIRST_WORD 9'h001
`define PW_LAST_WORD 9'h010
`define CTRL_ID_BIT 0
`define CTRL_LEVEL_BIT 8
`define TRIES_INIT 3'h5
`define TRIES_NONE 3'h0

// =========================================
// Status, error, security and interrupt bits
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ERR_ABRT 2
`define ERR_SHIFT 8
`define SEC_ENABLED 0
`define SEC_LOCKED 1
`define SEC_FROZEN 2
`define SEC_ARMED 3
`define SEC_MAX 4
`define SEC_EXPIRED 5
`define SEC_TRIES_LO 8
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define IRQ_DRQ 2

// =========================================
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: design/drive_sec_pkg.sv
// Types shared by the drive security command gate
package drive_sec_pkg;

  typedef logic [15:0] sector_word_t;
  typedef logic [255:0] password_t;
  typedef enum logic [1:0] {S_IDLE, S_XFER, S_EXEC} cmd_state_t;

endpackage : drive_sec_pkg

// file: design/sector_capture.sv
// Captures one data sector: control word and password
`timescale 1ns/1ps
`include "drive_sec_cfg.svh"

module sector_capture (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sector stream
  input wire logic start,
  input wire logic word_valid,
  input wire drive_sec_pkg::sector_word_t word,
  // Captured fields
  output logic sel_master,
  output logic level_max,
  output drive_sec_pkg::password_t password,
  output logic full
);
  import drive_sec_pkg::*;

  logic [8:0] count;

  // =========================================
  // Word counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || start)
      count <= 9'h000;
    else if (word_valid && count != `SECTOR_WORDS)
      count <= count + 9'h001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      full <= 1'b0;
    else
      full <= word_valid && (count == `SECTOR_WORDS - 9'h001);
  end

  // =========================================
  // Field capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_master <= 1'b0;
      level_max <= 1'b0;
      password <= '0;
    end
    else if (word_valid && count == 9'h000)
    begin
      sel_master <= word[`CTRL_ID_BIT];
      level_max <= word[`CTRL_LEVEL_BIT];
    end
    else if (word_valid && count >= `PW_FIRST_WORD && count <= `PW_LAST_WORD)
      password <= {word, password[255:16]};
  end

endmodule : sector_capture

// file: design/drive_sec_gate.sv
// Drive security command gate with AXI4-Lite register access
// Overview of operation
// - Erase-unit F4h only right after prepare
// - Erase without preceding prepare aborts, no erase
// - One sector: word0 bit0 target, password
// - Erase password mismatch aborts command
// - Erase wipes data, clears lock, keeps master
// - Freeze F5h enters frozen, blocks lock changes
// - Only power-on or hard reset unfreezes
// - Freeze while frozen completes, stays frozen
// - Frozen rejects set, unlock, disable, prepare, erase
// - Disable F6h only when unlocked, else abort
// - Disable matching user or master clears lock
// - Disable keeps stored master password
// - Prepare F3h arms erase, guards accidents
// - Five unlock tries; zero blocks unlock, erase
// - New user password locks at hard reset
`timescale 1ns/1ps
`include "drive_sec_cfg.svh"

module drive_sec_gate (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Hard reset pin
  input wire logic hard_reset,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive side
  output logic erase_req,
  output logic irq
);
  import drive_sec_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    return addr == `ADDR_CMD || addr == `ADDR_DATA || addr == `ADDR_STATUS ||
           addr == `ADDR_SEC || addr == `ADDR_IRQ_STAT || addr == `ADDR_IRQ_MASK;
  endfunction : mapped

  // =========================================
  // Hard reset pin synchroniser
  logic hrst_s1;
  logic hrst_s2;
  logic hrst_s3;
  logic hrst_lvl;
  logic hrst_prev;
  logic hard_pulse;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hrst_s1 <= 1'b0;
      hrst_s2 <= 1'b0;
      hrst_s3 <= 1'b0;
      hrst_lvl <= 1'b0;
      hrst_prev <= 1'b0;
    end
    else
    begin
      hrst_s1 <= hard_reset;
      hrst_s2 <= hrst_s1;
      hrst_s3 <= hrst_s2;
      if (hrst_s2 == hrst_s3)
        hrst_lvl <= hrst_s3;
      hrst_prev <= hrst_lvl;
    end
  end

  assign hard_pulse = hrst_lvl && !hrst_prev;

  // =========================================
  // AXI4-Lite write path
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // =========================================
  // Security state
  cmd_state_t state;
  logic [7:0] cur_op;
  logic lock_enabled;
  logic locked;
  logic frozen;
  logic armed;
  logic level_max;
  logic [2:0] tries;
  password_t user_pw;
  password_t master_pw;
  logic abrt;

  logic cmd_wr;
  logic data_wr;
  logic [7:0] op;
  logic pre_abort;
  logic expired;
  logic cap_master;
  logic cap_level;
  password_t cap_pw;
  logic cap_full;
  logic user_ok;
  logic master_ok;
  logic exec_fail;

  assign cmd_wr = wr_go && aw_addr == `ADDR_CMD && w_strb[0] && state == S_IDLE;
  assign data_wr = wr_go && aw_addr == `ADDR_DATA && (&w_strb[1:0]) && state == S_XFER;
  assign op = w_data[7:0];
  assign expired = tries == `TRIES_NONE;
  assign user_ok = cap_pw == user_pw;
  assign master_ok = cap_pw == master_pw;

  // Checks made before any data moves
  always_comb
  begin
    pre_abort = 1'b0;
    unique case (op)
      `OP_SET_PW: pre_abort = frozen;
      `OP_UNLOCK: pre_abort = frozen || expired;
      `OP_PREPARE: pre_abort = frozen;
      `OP_ERASE: pre_abort = frozen || expired || !armed;
      `OP_DISABLE: pre_abort = frozen || locked;
      `OP_FREEZE: pre_abort = 1'b0;
      default: pre_abort = 1'b1;
    endcase
  end

  // Password checks once the sector is in
  always_comb
  begin
    exec_fail = 1'b0;
    unique case (cur_op)
      `OP_UNLOCK: exec_fail = cap_master ? (level_max || !master_ok) : !user_ok;
      `OP_ERASE: exec_fail = cap_master ? !master_ok : !user_ok;
      `OP_DISABLE: exec_fail = !user_ok && !master_ok;
      default: exec_fail = 1'b0;
    endcase
  end

  sector_capture u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cmd_wr),
    .word_valid(data_wr),
    .word(w_data[15:0]),
    .sel_master(cap_master),
    .level_max(cap_level),
    .password(cap_pw),
    .full(cap_full)
  );

  // =========================================
  // Command sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hard_pulse)
    begin
      state <= S_IDLE;
      cur_op <= 8'h00;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (cmd_wr)
          begin
            cur_op <= op;
            if (!pre_abort && op != `OP_PREPARE && op != `OP_FREEZE)
              state <= S_XFER;
          end
        S_XFER:
          if (cap_full)
            state <= S_EXEC;
        S_EXEC:
          state <= S_IDLE;
      endcase
    end
  end

  // Abort flag: no other command block field changes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      abrt <= 1'b0;
    else if (cmd_wr)
      abrt <= pre_abort;
    else if (state == S_EXEC)
      abrt <= exec_fail;
  end

  // Erase arming
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hard_pulse)
      armed <= 1'b0;
    else if (cmd_wr)
      armed <= op == `OP_PREPARE && !pre_abort;
  end

  // Frozen mode, left only through reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hard_pulse)
      frozen <= 1'b0;
    else if (cmd_wr && op == `OP_FREEZE)
      frozen <= 1'b1;
  end

  // Unlock attempt counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hard_pulse)
      tries <= `TRIES_INIT;
    else if (state == S_EXEC && cur_op == `OP_UNLOCK && exec_fail && locked && !expired)
      tries <= tries - 3'h1;
  end

  // Lock function and lock state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_enabled <= 1'b0;
      locked <= 1'b0;
      level_max <= 1'b0;
    end
    else if (hard_pulse)
      locked <= lock_enabled;
    else if (state == S_EXEC && !exec_fail)
    begin
      unique case (cur_op)
        `OP_SET_PW:
          if (!cap_master)
          begin
            lock_enabled <= 1'b1;
            level_max <= cap_level;
          end
        `OP_UNLOCK:
          locked <= 1'b0;
        `OP_ERASE:
        begin
          lock_enabled <= 1'b0;
          locked <= 1'b0;
        end
        `OP_DISABLE:
          lock_enabled <= 1'b0;
        default:
          locked <= locked;
      endcase
    end
  end

  // Stored passwords; erase and disable leave master alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      user_pw <= '0;
      master_pw <= '0;
    end
    else if (state == S_EXEC && cur_op == `OP_SET_PW)
    begin
      if (cap_master)
        master_pw <= cap_pw;
      else
        user_pw <= cap_pw;
    end
  end

  // Erase request to the media side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      erase_req <= 1'b0;
    else
      erase_req <= state == S_EXEC && cur_op == `OP_ERASE && !exec_fail;
  end

  // =========================================
  // Interrupts
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [31:0] mask_word;

  assign mask_word = merge({29'h0, irq_mask}, w_data, w_strb);

  always_comb
  begin
    irq_set = 3'h0;
    irq_set[`IRQ_DONE] = (cmd_wr && !pre_abort && (op == `OP_PREPARE || op == `OP_FREEZE)) ||
                         (state == S_EXEC && !exec_fail);
    irq_set[`IRQ_ABORT] = (cmd_wr && pre_abort) || (state == S_EXEC && exec_fail);
    irq_set[`IRQ_DRQ] = cmd_wr && !pre_abort && op != `OP_PREPARE && op != `OP_FREEZE;
    irq_clr = 3'h0;
    if (wr_go && aw_addr == `ADDR_IRQ_STAT && w_strb[0])
      irq_clr = w_data[2:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= 3'h0;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= 3'h0;
    else if (wr_go && aw_addr == `ADDR_IRQ_MASK)
      irq_mask <= mask_word[2:0];
  end

  assign irq = |(irq_stat & irq_mask);

  // =========================================
  // AXI4-Lite read path
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `ADDR_CMD: rd_word[7:0] = cur_op;
      `ADDR_STATUS:
      begin
        rd_word[`ST_BSY] = state == S_EXEC;
        rd_word[`ST_DRDY] = state != S_EXEC;
        rd_word[`ST_DRQ] = state == S_XFER;
        rd_word[`ST_ERR] = abrt;
        rd_word[`ERR_SHIFT + `ERR_ABRT] = abrt;
      end
      `ADDR_SEC:
      begin
        rd_word[`SEC_ENABLED] = lock_enabled;
        rd_word[`SEC_LOCKED] = locked;
        rd_word[`SEC_FROZEN] = frozen;
        rd_word[`SEC_ARMED] = armed;
        rd_word[`SEC_MAX] = level_max;
        rd_word[`SEC_EXPIRED] = expired;
        rd_word[`SEC_TRIES_LO +: 3] = tries;
      end
      `ADDR_IRQ_STAT: rd_word[2:0] = irq_stat;
      `ADDR_IRQ_MASK: rd_word[2:0] = irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : drive_sec_gate

// file: test/drive_sec_gate_monitor.sv
// Port checker for the drive security gate
`timescale 1ns/1ps

module drive_sec_gate_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive side
  input wire logic erase_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ========
  // Bus timing
  a_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  a_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_resp_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer stays");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_block: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("address taken while answering");
  a_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");

  // ========
  // Drive side
  a_erase_pulse: assert property (
    erase_req |=> !erase_req) else $error("erase request too long");
  a_reset_idle: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !erase_req)
    else $error("outputs busy after reset");
endmodule : drive_sec_gate_monitor

bind drive_sec_gate drive_sec_gate_monitor mon_u (.*);

// file: test/host_model.sv
// Host controller model: register bus master
`timescale 1ns/1ps

module host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [1:0] last_bresp;

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // ========
  // One word write, entered just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    @(posedge aclk);
  endtask : wr

  // ========
  // One word read, data taken at the answer edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
endmodule : host_model

// file: test/tb.sv
// Testbench of the drive security gate
`timescale 1ns/1ps
`include "drive_sec_cfg.svh"

module tb;
  import drive_sec_pkg::*;
  logic aclk, aresetn, hard_reset, erase_req, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int n_checks = 0;
  int erases = 0;
  logic [7:0] ops[5] = '{`OP_SET_PW, `OP_UNLOCK, `OP_PREPARE, `OP_ERASE, `OP_DISABLE};

  drive_sec_gate dut_u (.*);
  host_model host_u (.*);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
    if (erase_req === 1'b1) erases <= erases + 1;

  // ========
  // Shared tasks
  task automatic complete_run;
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic st(input logic [31:0] e);
    host_u.rd(`ADDR_STATUS, rdat, rsp);
    chk("status", e, rdat & 32'h401);
  endtask : st

  task automatic sec(input logic [31:0] e);
    host_u.rd(`ADDR_SEC, rdat, rsp);
    chk("security", e, rdat & 32'h70f);
  endtask : sec

  task automatic cmd(input logic [7:0] op);
    host_u.wr(`ADDR_CMD, {24'h0, op});
  endtask : cmd

  task automatic sector(input logic [7:0] op, input logic sel, input logic [7:0] k);
    cmd(op);
    for (int i = 0; i < `SECTOR_WORDS; i++)
      host_u.wr(`ADDR_DATA, i == 0 ? {31'h0, sel} : (i <= 16 ? {16'h0, k, k} : 32'h0));
    repeat (2) @(posedge aclk);
  endtask : sector

  // ========
  // Scenarios
  task automatic t_reset;
    sec(32'h500);
    host_u.rd(8'h18, rdat, rsp);
    chk("unmapped", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    host_u.wr(8'h18, 32'h0);
    chk("wresp", {30'h0, `RESP_SLVERR}, {30'h0, host_u.last_bresp});
    host_u.wr(`ADDR_IRQ_MASK, 32'h0);
    chk("wresp", {30'h0, `RESP_OKAY}, {30'h0, host_u.last_bresp});
  endtask : t_reset

  task automatic t_erase;
    sector(`OP_SET_PW, 1'b0, 8'ha5);
    sec(32'h501);
    cmd(`OP_ERASE);
    st(32'h401);
    chk("irq", 32'h0, {31'h0, irq});
    cmd(`OP_PREPARE);
    sec(32'h509);
    sector(`OP_ERASE, 1'b0, 8'h5a);
    st(32'h401);
    chk("erases", 32'h0, erases);
    cmd(`OP_PREPARE);
    sector(`OP_ERASE, 1'b0, 8'ha5);
    st(32'h0);
    chk("erases", 32'h1, erases);
    sec(32'h500);
  endtask : t_erase

  task automatic t_disable;
    repeat (2)
    begin
      sector(`OP_SET_PW, 1'b0, 8'h3c);
      sector(`OP_DISABLE, 1'b1, 8'h00);
      st(32'h0);
      sec(32'h500);
    end
    sector(`OP_SET_PW, 1'b0, 8'h3c);
  endtask : t_disable

  task automatic t_freeze;
    cmd(`OP_PREPARE);
    cmd(`OP_FREEZE);
    sec(32'h505);
    cmd(`OP_FREEZE);
    st(32'h0);
    foreach (ops[i])
    begin
      cmd(ops[i]);
      st(32'h401);
    end
    sec(32'h505);
  endtask : t_freeze

  task automatic t_hard;
    hard_reset <= 1'b1;
    repeat (6) @(posedge aclk);
    hard_reset <= 1'b0;
    repeat (6) @(posedge aclk);
    sec(32'h503);
    host_u.wr(`ADDR_IRQ_MASK, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    host_u.wr(`ADDR_IRQ_STAT, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    cmd(`OP_DISABLE);
    st(32'h401);
    chk("irq", 32'h1, {31'h0, irq});
  endtask : t_hard

  task automatic t_unlock;
    sector(`OP_UNLOCK, 1'b0, 8'h5a);
    st(32'h401);
    sec(32'h403);
  endtask : t_unlock

  // ========
  // Main sequence and watchdog
  initial
  begin
    aresetn = 1'b0;
    hard_reset = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_erase;
    t_disable;
    t_freeze;
    t_hard;
    t_unlock;
    complete_run;
  end

  initial
  begin
    #500000;
    failures++;
    complete_run;
  end
endmodule : tb
